// ---- verilog/msc_step_ctrl.sv ----
// Step control core: serial write slave, step gate, divider, position, references
`timescale 1ns/1ps
module msc_step_ctrl
   import msc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
   parameter int POS_W = POS_W_DEFAULT,
   parameter logic [15:0] CHOP_LEN = CHOP_CYCLES
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic step_clk_in,
   input wire logic coil_below_a,
   input wire logic coil_below_b,
   output logic [POS_W-1:0] position,
   output logic step_held,
   output logic [3:0] ref_code_a,
   output logic [3:0] ref_code_b,
   output logic [7:0] ref_mv_a,
   output logic [7:0] ref_mv_b,
   output msc_drv_t drive_mode_a,
   output msc_drv_t drive_mode_b
);

   // Pin synchronisers
   logic scl_m1, scl_s, scl_prev;
   logic sda_m1, sda_s, sda_prev;
   logic step_m1, step_s;
   logic cba_m1, cba_s;
   logic cbb_m1, cbb_s;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_m1 <= 1'b1;
         scl_s <= 1'b1;
         scl_prev <= 1'b1;
         sda_m1 <= 1'b1;
         sda_s <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_m1 <= scl;
         scl_s <= scl_m1;
         scl_prev <= scl_s;
         sda_m1 <= sda_in;
         sda_s <= sda_m1;
         sda_prev <= sda_s;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         step_m1 <= 1'b0;
         step_s <= 1'b0;
         cba_m1 <= 1'b0;
         cba_s <= 1'b0;
         cbb_m1 <= 1'b0;
         cbb_s <= 1'b0;
      end else begin
         step_m1 <= step_clk_in;
         step_s <= step_m1;
         cba_m1 <= coil_below_a;
         cba_s <= cba_m1;
         cbb_m1 <= coil_below_b;
         cbb_s <= cbb_m1;
      end
   end

   wire scl_rise = scl_s & ~scl_prev;
   wire scl_fall = ~scl_s & scl_prev;
   wire start_det = scl_s & scl_prev & sda_prev & ~sda_s;
   wire stop_det = scl_s & scl_prev & ~sda_prev & sda_s;

   // Serial write slave
   msc_i2c_st_t st_reg, st_next;
   logic [2:0] bit_reg, bit_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] addr_reg, addr_next;
   logic sda_oe_reg, sda_oe_next;

   wire [7:0] byte_in = {shift_reg[6:0], sda_s};
   wire byte_done = (bit_reg == 3'h7);
   wire in_ack = (st_reg == I2_ACKD) || (st_reg == I2_ACKR) || (st_reg == I2_ACKW);
   wire dev_hit = (byte_in[7:1] == DEV_ADDR) && !byte_in[0];
   wire wr_pulse = scl_rise && byte_done && (st_reg == I2_DATA) && !start_det && !stop_det;
   wire [7:0] wr_data = byte_in;
   wire [7:0] wr_addr = addr_reg;

   always_comb begin
      st_next = st_reg;
      bit_next = bit_reg;
      shift_next = shift_reg;
      addr_next = addr_reg;
      sda_oe_next = sda_oe_reg;
      if (start_det) begin
         st_next = I2_DEV;
         bit_next = 3'h0;
         sda_oe_next = 1'b0;
      end else if (stop_det) begin
         st_next = I2_IDLE;
         sda_oe_next = 1'b0;
      end else begin
         if (scl_fall) begin
            sda_oe_next = in_ack;
         end
         if (scl_rise) begin
            unique case (st_reg)
               I2_IDLE: begin
                  st_next = I2_IDLE;
               end
               I2_DEV, I2_REG, I2_DATA: begin
                  shift_next = byte_in;
                  bit_next = 3'(bit_reg + 3'h1);
                  if (byte_done && st_reg == I2_DEV) begin
                     st_next = dev_hit ? I2_ACKD : I2_IDLE;
                  end else if (byte_done && st_reg == I2_REG) begin
                     addr_next = byte_in;
                     st_next = I2_ACKR;
                  end else if (byte_done) begin
                     addr_next = 8'(addr_reg + 8'h01);
                     st_next = I2_ACKW;
                  end
               end
               I2_ACKD: begin
                  st_next = I2_REG;
               end
               I2_ACKR, I2_ACKW: begin
                  st_next = I2_DATA;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= I2_IDLE;
         bit_reg <= 3'h0;
         shift_reg <= 8'h00;
         addr_reg <= 8'h00;
         sda_oe_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         addr_reg <= addr_next;
         sda_oe_reg <= sda_oe_next;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_reg;

   // Setting registers, written at the 8th clock rise of a data byte
   logic [3:0] ref_a_reg, ref_b_reg;
   logic [7:0] mv_a_reg, mv_b_reg;
   logic hold_reg, cnt_rst_reg;
   logic [1:0] ratio_reg;

   wire wr_ref_a = wr_pulse && (wr_addr == REG_REF_A);
   wire wr_ref_b = wr_pulse && (wr_addr == REG_REF_B);
   wire wr_ctrl = wr_pulse && (wr_addr == REG_CTRL);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_a_reg <= REF_RESET;
         ref_b_reg <= REF_RESET;
         mv_a_reg <= 8'(REF_MAX_MV);
         mv_b_reg <= 8'(REF_MAX_MV);
      end else begin
         if (wr_ref_a) begin
            ref_a_reg <= wr_data[3:0];
            mv_a_reg <= msc_ref_mv(wr_data[3:0]);
         end
         if (wr_ref_b) begin
            ref_b_reg <= wr_data[3:0];
            mv_b_reg <= msc_ref_mv(wr_data[3:0]);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_reg <= 1'b0;
         cnt_rst_reg <= 1'b0;
         ratio_reg <= DIV_RESET;
      end else if (wr_ctrl) begin
         hold_reg <= wr_data[CTRL_HOLD_BIT];
         cnt_rst_reg <= wr_data[CTRL_CNT_RST_BIT];
         ratio_reg <= wr_data[CTRL_DIV_MSB:CTRL_DIV_LSB];
      end
   end

   // Step gate, divider and position counter
   logic int_clk_reg, int_prev_reg;
   logic [2:0] div_reg, div_next;
   logic [1:0] ratio_act_reg;
   logic [POS_W-1:0] pos_reg, pos_next;

   wire int_clk_next = hold_reg ? int_clk_reg : step_s;
   wire int_rise = int_clk_reg & ~int_prev_reg;
   wire div_hit = (div_reg == msc_div_mask(ratio_act_reg));
   wire advance = int_rise && !hold_reg && !cnt_rst_reg && div_hit;
   wire cnt_clear = cnt_rst_reg || (wr_ctrl && wr_data[CTRL_CNT_RST_BIT]);

   assign div_next = (cnt_clear || (int_rise && (div_hit || ratio_reg != ratio_act_reg))) ?
                     3'h0 : (int_rise ? 3'(div_reg + 3'h1) : div_reg);
   assign pos_next = cnt_clear ? '0 : (advance ? POS_W'(pos_reg + 1'b1) : pos_reg);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         int_clk_reg <= 1'b0;
         int_prev_reg <= 1'b0;
      end else begin
         int_clk_reg <= int_clk_next;
         int_prev_reg <= int_clk_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_reg <= 3'h0;
         ratio_act_reg <= DIV_RESET;
         pos_reg <= '0;
      end else begin
         div_reg <= div_next;
         pos_reg <= pos_next;
         if (int_rise) begin
            ratio_act_reg <= ratio_reg;
         end
      end
   end

   assign position = pos_reg;
   assign step_held = hold_reg;
   assign ref_code_a = ref_a_reg;
   assign ref_code_b = ref_b_reg;
   assign ref_mv_a = mv_a_reg;
   assign ref_mv_b = mv_b_reg;

   // Chopping period timebase and the two sequencers
   logic [15:0] chop_cnt_reg;
   wire chop_wrap = (chop_cnt_reg == CHOP_LEN - 16'h0001);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         chop_cnt_reg <= 16'h0000;
      end else begin
         chop_cnt_reg <= chop_wrap ? 16'h0000 : 16'(chop_cnt_reg + 16'h0001);
      end
   end

   msc_chop_if chop_a_if ();
   msc_chop_if chop_b_if ();

   assign chop_a_if.period_start = chop_wrap;
   assign chop_a_if.coil_below = cba_s;
   assign chop_b_if.period_start = chop_wrap;
   assign chop_b_if.coil_below = cbb_s;
   assign drive_mode_a = chop_a_if.mode;
   assign drive_mode_b = chop_b_if.mode;

   msc_chopper u_chop_a (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .chop_bus(chop_a_if.chop)
   );

   msc_chopper u_chop_b (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .chop_bus(chop_b_if.chop)
   );

   sequence s_ctrl_reset_write;
      wr_ctrl && wr_data[CTRL_CNT_RST_BIT];
   endsequence

   a_hold_latch: assert property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(hold_reg) |-> int_clk_reg == $past(step_s) ##1 $stable(int_clk_reg))
      else $error("held step level changed");
   a_hold_freeze: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (hold_reg && $past(hold_reg) && !cnt_rst_reg) |-> $stable(pos_reg))
      else $error("position moved while held");
   a_clear_follow: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !$past(hold_reg) |-> int_clk_reg == $past(step_s))
      else $error("internal step clock not following external");
   a_reset_pos: assert property (@(posedge sys_clk) disable iff (!arst_n)
      s_ctrl_reset_write |=> pos_reg == '0 ##1 pos_reg == '0)
      else $error("counter reset did not clear position");
   a_step_one: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (int_rise && ratio_act_reg == 2'h0 && !hold_reg && !cnt_clear)
      |=> pos_reg == POS_W'($past(pos_reg) + 1'b1))
      else $error("undivided step did not advance by one");
   a_ref_a_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_ref_a |=> ref_code_a == $past(wr_data[3:0]) && ref_mv_a == msc_ref_mv(ref_code_a))
      else $error("pair A reference not updated at write");
   a_ref_b_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_ref_b |=> ref_code_b == $past(wr_data[3:0]) && $stable(ref_code_a))
      else $error("pair B reference write misrouted");
   a_write_8th: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wr_pulse |-> scl_rise && bit_reg == 3'h7 && st_reg == I2_DATA)
      else $error("setting captured off the 8th clock rise");

endmodule

// ---- inc/msc_pkg.sv ----
// Package of constants, types and helpers for the microstep step control block
package msc_pkg;

   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_PERIOD_NS = 25;

   localparam logic [7:0] REG_REF_A = 8'h00;
   localparam logic [7:0] REG_REF_B = 8'h01;
   localparam logic [7:0] REG_CTRL = 8'h02;

   localparam int CTRL_HOLD_BIT = 0;
   localparam int CTRL_CNT_RST_BIT = 1;
   localparam int CTRL_DIV_LSB = 2;
   localparam int CTRL_DIV_MSB = 3;

   localparam logic [3:0] REF_RESET = 4'h0;
   localparam logic [1:0] DIV_RESET = 2'h0;
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

   localparam int REF_MAX_MV = 200;
   localparam int REF_STEP_MV = 10;

   localparam int POS_W_DEFAULT = 8;

   localparam int CHOP_PERIOD_NS = 10000;
   localparam int FORCE_CHARGE_NS = 500;
   localparam int SLOW_DECAY_NS = 2500;
   localparam logic [15:0] CHOP_CYCLES = 16'(CHOP_PERIOD_NS / CLK_PERIOD_NS);
   localparam logic [15:0] FORCE_CYCLES =
      16'((FORCE_CHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] SLOW_CYCLES = 16'(SLOW_DECAY_NS / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      DRV_CHARGE = 3'b001,
      DRV_SLOW = 3'b010,
      DRV_FAST = 3'b100
   } msc_drv_t;

   typedef enum logic [3:0] {
      CH_FORCED = 4'b0001,
      CH_CHARGE = 4'b0010,
      CH_SLOW = 4'b0100,
      CH_FAST = 4'b1000
   } msc_chop_st_t;

   typedef enum logic [6:0] {
      I2_IDLE = 7'b0000001,
      I2_DEV = 7'b0000010,
      I2_ACKD = 7'b0000100,
      I2_REG = 7'b0001000,
      I2_ACKR = 7'b0010000,
      I2_DATA = 7'b0100000,
      I2_ACKW = 7'b1000000
   } msc_i2c_st_t;

   function automatic logic [7:0] msc_ref_mv(input logic [3:0] code);
      return 8'(REF_MAX_MV - REF_STEP_MV * int'(code));
   endfunction

   function automatic logic [2:0] msc_div_mask(input logic [1:0] ratio);
      return 3'((1 << ratio) - 1);
   endfunction

endpackage

// ---- inc/msc_chop_if.sv ----
// Interface between the step control core and one chopping sequencer
`timescale 1ns/1ps
interface msc_chop_if;
   import msc_pkg::*;
   logic period_start;
   logic coil_below;
   msc_drv_t mode;

   modport ctl (
      output period_start,
      output coil_below,
      input mode
   );

   modport chop (
      input period_start,
      input coil_below,
      output mode
   );
endinterface

// ---- verilog/msc_chopper.sv ----
// Chopping sequencer for one channel pair: charge, slow decay, fast decay
`timescale 1ns/1ps
module msc_chopper
   import msc_pkg::*;
#(
   parameter logic [15:0] FORCE_LEN = FORCE_CYCLES,
   parameter logic [15:0] SLOW_LEN = SLOW_CYCLES
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   msc_chop_if.chop chop_bus
);

   msc_chop_st_t st_reg, st_next;
   logic [15:0] cnt_reg, cnt_next;
   logic seen_reg, seen_next;
   msc_drv_t mode_next;

   wire force_end = (st_reg == CH_FORCED) && (cnt_reg == FORCE_LEN - 16'h0001);
   wire slow_end = (st_reg == CH_SLOW) && (cnt_reg == SLOW_LEN - 16'h0001);
   wire below = chop_bus.coil_below;

   always_comb begin
      st_next = st_reg;
      cnt_next = 16'(cnt_reg + 16'h0001);
      seen_next = seen_reg;
      if (chop_bus.period_start) begin
         st_next = CH_FORCED;
         cnt_next = 16'h0000;
         seen_next = below;
      end else begin
         unique case (st_reg)
            CH_FORCED: begin
               seen_next = seen_reg | below;
               if (force_end) begin
                  cnt_next = 16'h0000;
                  if (seen_reg | below) begin
                     st_next = below ? CH_CHARGE : CH_SLOW;
                  end else begin
                     st_next = CH_FAST;
                  end
               end
            end
            CH_CHARGE: begin
               if (!below) begin
                  st_next = CH_SLOW;
                  cnt_next = 16'h0000;
               end
            end
            CH_SLOW: begin
               if (slow_end) begin
                  st_next = CH_FAST;
               end
            end
            CH_FAST: begin
               cnt_next = cnt_reg;
            end
         endcase
      end
   end

   assign mode_next = (st_next == CH_FORCED || st_next == CH_CHARGE) ? DRV_CHARGE :
                      (st_next == CH_SLOW) ? DRV_SLOW : DRV_FAST;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= CH_FAST;
         cnt_reg <= 16'h0000;
         seen_reg <= 1'b0;
         chop_bus.mode <= DRV_FAST;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         seen_reg <= seen_next;
         chop_bus.mode <= mode_next;
      end
   end

   sequence s_force_end_low;
      force_end && !chop_bus.period_start && !seen_reg && !below;
   endsequence

   sequence s_force_end_below;
      force_end && !chop_bus.period_start && below;
   endsequence

   a_period_charge: assert property (@(posedge sys_clk) disable iff (!arst_n)
      chop_bus.period_start |=> st_reg == CH_FORCED && chop_bus.mode == DRV_CHARGE)
      else $error("period start did not enter forced charge");
   a_low_to_fast: assert property (@(posedge sys_clk) disable iff (!arst_n)
      s_force_end_low |=> chop_bus.mode == DRV_FAST)
      else $error("no low current seen but not fast decay");
   a_below_charge: assert property (@(posedge sys_clk) disable iff (!arst_n)
      s_force_end_below ##1 (!below && !chop_bus.period_start) |=> chop_bus.mode == DRV_SLOW)
      else $error("charge did not end in slow decay");
   a_fast_stays: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (st_reg == CH_FAST && !chop_bus.period_start) |=> st_reg == CH_FAST)
      else $error("fast decay left before period end");

endmodule

// ---- tb/msc_host_model.sv ----
// Host model: serial write master and external step clock source
`timescale 1ns/1ps
module msc_host_model (
   input wire logic sys_clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low,
   output logic step_clk
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      step_clk = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic set_step(input logic b);
      step_clk = b;
   endtask
   // Data changes only while scl is low
   task automatic put_bit(input logic b, output logic seen);
      sda_low = ~b;
      tick(4);
      scl = 1'b1;
      tick(5);
      seen = sda_line;
      scl = 1'b0;
      tick(1);
   endtask
   task automatic put_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(v[i], s);
      end
      put_bit(1'b1, s);
      ack = ~s;
   endtask
   // Device byte, register address byte then data byte, each byte completed with its ninth clock
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] addr,
                            input logic [7:0] data, output logic acked);
      logic a0, a1, a2;
      tick(5);
      sda_low = 1'b1;
      tick(5);
      scl = 1'b0;
      tick(1);
      put_byte({dev, 1'b0}, a0);
      put_byte(addr, a1);
      put_byte(data, a2);
      sda_low = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(5);
      sda_low = 1'b0;
      tick(5);
      acked = a0 & a1 & a2;
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         step_clk = 1'b1;
         tick(4);
         step_clk = 1'b0;
         tick(4);
      end
   endtask
endmodule

// ---- tb/msc_step_ctrl_tb.sv ----
// Self-checking testbench for the step control block
`timescale 1ns/1ps
module msc_step_ctrl_tb;
   import msc_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic scl, sda_low, step_clk, sda_out, sda_oe, step_held;
   logic coil_below_a = 1'b0;
   logic coil_below_b = 1'b0;
   logic [7:0] position;
   logic [3:0] ref_code_a, ref_code_b;
   logic [7:0] ref_mv_a, ref_mv_b;
   msc_drv_t drive_mode_a, drive_mode_b;
   wire logic sda_line = !(sda_low || (sda_oe && !sda_out));
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [31:0] rng = 32'h0000004C;
   logic [7:0] exp_pos = 8'h00;
   logic [7:0] pos_seen = 8'h00;
   logic [15:0] ref_seen = 16'hC8C8;
   logic mon_on = 1'b1;
   logic [7:0] q_pos[$];
   logic [15:0] q_ref[$];

   always #12.5 sys_clk = ~sys_clk;

   msc_host_model i_host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
      .sda_low(sda_low), .step_clk(step_clk));

   msc_step_ctrl i_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .step_clk_in(step_clk),
      .coil_below_a(coil_below_a), .coil_below_b(coil_below_b), .position(position),
      .step_held(step_held), .ref_code_a(ref_code_a), .ref_code_b(ref_code_b),
      .ref_mv_a(ref_mv_a), .ref_mv_b(ref_mv_b), .drive_mode_a(drive_mode_a),
      .drive_mode_b(drive_mode_b));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [7:0] ref_v(input logic [3:0] c);
      return 8'(REF_MAX_MV - REF_STEP_MV * int'(c));
   endfunction
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic note_pos(input int n);
      repeat (n) begin
         exp_pos++;
         q_pos.push_back(exp_pos);
      end
   endtask
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      logic ack;
      i_host.write_reg(DEV_ADDR_DEFAULT, addr, data, ack);
      chk_val(16'(ack), 16'h0001);
   endtask
   task automatic wait_charge();
      int k;
      k = 0;
      while (drive_mode_a === DRV_CHARGE && k < 500) begin
         i_host.tick(1);
         k++;
      end
      while (drive_mode_a !== DRV_CHARGE && k < 500) begin
         i_host.tick(1);
         k++;
      end
      chk_val(16'(drive_mode_b), 16'(DRV_CHARGE));
   endtask

   // Watches position while mon_on is set and the reference levels always, taking the oldest note on each change
   always @(negedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_mismatch++;
         tally_and_finish();
      end
      if (mon_on && position !== pos_seen) begin
         chk_val(16'(position), 16'(q_pos.size() > 0 ? q_pos.pop_front() : 8'hEE));
      end
      pos_seen = position;
      if ({ref_mv_b, ref_mv_a} !== ref_seen) begin
         chk_val({ref_mv_b, ref_mv_a}, q_ref.size() > 0 ? q_ref.pop_front() : 16'hEEEE);
      end
      ref_seen = {ref_mv_b, ref_mv_a};
   end

   initial begin
      logic ack;
      logic [3:0] ca, cb;
      repeat (4) @(posedge sys_clk);
      #2;
      arst_n = 1'b1;
      i_host.tick(3);
      chk_val({ref_mv_b, ref_mv_a}, 16'hC8C8);
      // Hold latched low: rise while held is ignored, Clear with input high advances
      wr(REG_CTRL, 8'h01);
      chk_val(16'(step_held), 16'h0001);
      i_host.pulse(3);
      i_host.set_step(1'b1);
      i_host.tick(8);
      note_pos(1);
      wr(REG_CTRL, 8'h00);
      i_host.set_step(1'b0);
      i_host.tick(4);
      note_pos(1);
      i_host.pulse(1);
      // Hold latched high: Clear with input low gives no advance
      note_pos(1);
      i_host.set_step(1'b1);
      i_host.tick(8);
      wr(REG_CTRL, 8'h01);
      i_host.set_step(1'b0);
      i_host.pulse(2);
      wr(REG_CTRL, 8'h00);
      chk_val(16'(step_held), 16'h0000);
      note_pos(1);
      i_host.pulse(1);
      // Every division ratio from a clean counter reset
      for (int r = 3; r >= 0; r--) begin
         mon_on = 1'b0;
         wr(REG_CTRL, 8'(r << 2));
         i_host.pulse(8);
         wr(REG_CTRL, 8'(r << 2) | 8'h02);
         i_host.pulse(2);
         chk_val(16'(position), 16'h0000);
         i_host.tick(1);
         mon_on = 1'b1;
         exp_pos = 8'h00;
         wr(REG_CTRL, 8'(r << 2));
         note_pos(8 >> r);
         i_host.pulse(8);
      end
      note_pos(250);
      i_host.pulse(250);
      // Reference codes for both pairs, random upper bits ignored
      cb = 4'h0;
      for (int c = 1; c <= 16; c++) begin
         rng = xs(rng);
         ca = 4'(c);
         q_ref.push_back({ref_v(cb), ref_v(ca)});
         wr(REG_REF_A, {rng[7:4], ca});
         chk_val(16'(ref_code_a), 16'(ca));
         cb = ~ca;
         q_ref.push_back({ref_v(cb), ref_v(ca)});
         wr(REG_REF_B, {rng[15:12], cb});
         chk_val(16'(ref_code_b), 16'(cb));
      end
      i_host.write_reg(DEV_ADDR_DEFAULT ^ 7'h01, REG_REF_A, rng[23:16], ack);
      chk_val(16'(ack), 16'h0000);
      wr(8'h05, rng[31:24]);
      chk_val({ref_code_b, ref_code_a}, {8'h00, cb, ca});
      // Chopping: pair A never below, pair B below through forced charge
      coil_below_b = 1'b1;
      wait_charge();
      i_host.tick(30);
      chk_val(16'(drive_mode_a), 16'(DRV_FAST));
      chk_val(16'(drive_mode_b), 16'(DRV_CHARGE));
      coil_below_b = 1'b0;
      i_host.tick(10);
      chk_val(16'(drive_mode_b), 16'(DRV_SLOW));
      i_host.tick(100);
      chk_val(16'(drive_mode_b), 16'(DRV_FAST));
      wait_charge();
      // Roles swapped: pair A below through forced charge, pair B never below
      coil_below_a = 1'b1;
      i_host.tick(30);
      chk_val(16'(drive_mode_a), 16'(DRV_CHARGE));
      chk_val(16'(drive_mode_b), 16'(DRV_FAST));
      coil_below_a = 1'b0;
      i_host.tick(10);
      chk_val(16'(drive_mode_a), 16'(DRV_SLOW));
      chk_val(16'(q_pos.size() + q_ref.size()), 16'h0000);
      tally_and_finish();
   end
endmodule
